//--- src/rf_auth_access_control.sv
// RF login key check, retry budget, kill byte and protected-region gating.
// Assumes a protocol engine that presents one-cycle RF requests and a host
// interface (SPI or I2C) that presents one-cycle byte accesses.
`timescale 1ns/1ns
`include "rf_auth_cfg.svh"

module rf_auth_access_control (
	// Clock and reset.
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	// Host byte access.
	input  wire logic        i_host_wr,
	input  wire logic        i_host_rd,
	input  wire logic [3:0]  i_host_sel,
	input  wire logic [7:0]  i_host_wdata,
	output logic      [7:0]  o_host_rdata,
	// RF request from the protocol engine.
	input  wire logic        i_rf_req,
	input  wire logic [2:0]  i_rf_op,
	input  wire logic [3:0]  i_rf_cfg_sel,
	input  wire logic [7:0]  i_rf_wdata,
	input  wire logic [31:0] i_rf_key_data,
	input  wire logic [7:0]  i_rf_blk_addr,
	input  wire logic        i_rf_blk_locked,
	// Tag state and enables held in other configuration bytes.
	input  wire logic        i_rf_selected,
	input  wire logic        i_prot_set_en,
	input  wire logic        i_rfcfg_en,
	// RF answer.
	output logic             o_rf_done,
	output logic             o_rf_answer,
	output logic      [7:0]  o_rf_rdata,
	output logic      [3:0]  o_rf_read_mask,
	output logic             o_rf_to_sleep,
	// Status.
	output logic             o_authenticated,
	output logic             o_auth_lockout,
	output logic             o_rf_disabled,
	output logic             o_ext_modes_disabled,
	output logic      [7:0]  o_poll_answer_low
);

	// ------------------------------------------------------------
	// Stored bytes and state
	// ------------------------------------------------------------
	logic [31:0]               key_reg;
	logic [7:0]                kill_reg;
	logic [7:0]                retry_reg;
	logic [7:0]                floor_reg;
	logic [7:0]                opsel_reg;
	logic [7:0]                poll_reg;
	rf_auth_pkg::auth_state_t  state_reg;
	logic                      lockout_reg;
	logic                      done_reg;
	logic                      answer_reg;
	logic [7:0]                rdata_reg;
	logic [3:0]                mask_reg;
	logic                      sleep_reg;
	logic [7:0]                host_rdata_reg;

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	logic       rf_live;
	logic       authed;
	logic       lockout;
	logic       login_try;
	logic       login_ok;
	logic       login_bad;
	logic       key_ovr;
	logic       host_retry_wr;
	logic [2:0] ctr_dec;
	logic       cfg_rf_ok;
	logic       cfg_rf_wr;
	logic       region_live;
	logic       wr_prot;
	logic       wr_ok;
	logic [3:0] rd_mask;
	logic [7:0] cfg_rdata;
	logic [7:0] host_view;

	// A killed RF part answers no request; only done still follows the request.
	assign rf_live = i_rf_req & ~kill_reg[`KILL_RF_BIT];
	assign authed  = (state_reg == rf_auth_pkg::ST_AUTH);

	// Budget is gone at zero or when the two copies disagree.
	assign lockout = (retry_reg[2:0] == `CTR_ZERO)
		| (retry_reg[2:0] != retry_reg[6:4]);

	// A key write outside the authenticated state is a login attempt.
	assign login_try = rf_live & i_rf_selected & ~authed
		& (i_rf_op == rf_auth_pkg::OP_KEY_WR);
	assign login_ok  = login_try & ~lockout
		& (i_rf_key_data == key_reg);
	assign login_bad = login_try & ~login_ok;
	assign key_ovr   = rf_live & i_rf_selected & authed
		& (i_rf_op == rf_auth_pkg::OP_KEY_WR);
	assign host_retry_wr = i_host_wr & (i_host_sel == `SEL_RETRY);

	// Only ever decremented from a nonzero value, so it cannot wrap.
	assign ctr_dec = retry_reg[2:0] - `CTR_ONE;

	// RF may touch config bytes only under their own conditions.
	always_comb begin
		case (i_rf_cfg_sel)
			`SEL_KEY0, `SEL_KEY1, `SEL_KEY2, `SEL_KEY3: begin
				cfg_rf_ok = (i_rf_op == rf_auth_pkg::OP_CFG_RD);
			end
			`SEL_FLOOR, `SEL_OPSEL: begin
				cfg_rf_ok = authed & i_prot_set_en;
			end
			`SEL_POLL: begin
				cfg_rf_ok = i_rfcfg_en;
			end
			default: begin
				cfg_rf_ok = 1'b0;
			end
		endcase
	end
	assign cfg_rf_wr = rf_live & cfg_rf_ok
		& (i_rf_op == rf_auth_pkg::OP_CFG_WR);

	// RF view of a config byte; the key always reads back as zero.
	always_comb begin
		case (i_rf_cfg_sel)
			`SEL_FLOOR: cfg_rdata = floor_reg;
			`SEL_OPSEL: cfg_rdata = opsel_reg;
			`SEL_POLL:  cfg_rdata = poll_reg;
			default:    cfg_rdata = `BYTE_ZERO;
		endcase
	end

	// ------------------------------------------------------------
	// Protected region
	// ------------------------------------------------------------
	// A floor past the last block leaves nothing protected.
	assign region_live = (floor_reg <= `LAST_BLOCK);
	assign wr_prot = region_live & opsel_reg[`OP_WR_BIT]
		& (i_rf_blk_addr > floor_reg);
	// Lock bits win over authentication.
	// The lock input only ever reaches the RF write path, never the host.
	assign wr_ok = ~i_rf_blk_locked & (~wr_prot | authed);

	// One mask bit per block of a multi-block read.
	genvar gi;
	generate
		for (gi = 0; gi < `READ_BLOCKS; gi++) begin : g_rd
			logic [7:0] blk;
			assign blk = i_rf_blk_addr + 8'(gi);
			assign rd_mask[gi] = authed | ~(region_live
				& opsel_reg[`OP_RD_BIT] & (blk > floor_reg));
		end
	endgenerate

	// ------------------------------------------------------------
	// Login state
	// ------------------------------------------------------------
	// Deselection overrides a login in the same cycle.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_reg <= rf_auth_pkg::ST_OPEN;
		end else if (!i_rf_selected) begin
			state_reg <= rf_auth_pkg::ST_OPEN;
		end else if (login_ok) begin
			state_reg <= rf_auth_pkg::ST_AUTH;
		end else begin
			case (state_reg)
				rf_auth_pkg::ST_OPEN: state_reg <= rf_auth_pkg::ST_OPEN;
				rf_auth_pkg::ST_AUTH: state_reg <= rf_auth_pkg::ST_AUTH;
				default:              state_reg <= rf_auth_pkg::ST_OPEN;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Retry budget
	// ------------------------------------------------------------
	// Both copies change in one write; RF updates keep them paired, a host write may not; the host wins.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			retry_reg <= `RETRY_RST;
		end else if (host_retry_wr) begin
			retry_reg <= i_host_wdata & `RETRY_MASK;
		end else if (login_ok) begin
			retry_reg <= `RETRY_FULL;
		end else if (login_bad && !lockout) begin
			retry_reg <= {1'b0, ctr_dec, 1'b0, ctr_dec};
		end
	end

	// ------------------------------------------------------------
	// Key and configuration bytes
	// ------------------------------------------------------------
	// Host writes land byte by byte and are never gated.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			key_reg <= `KEY_RST;
		end else if (i_host_wr && i_host_sel <= `SEL_KEY3) begin
			key_reg[i_host_sel[1:0]*8 +: 8] <= i_host_wdata;
		end else if (key_ovr) begin
			key_reg <= i_rf_key_data;
		end
	end

	// Kill byte is host only; the bits take effect at once.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			kill_reg <= `KILL_RST;
		end else if (i_host_wr && i_host_sel == `SEL_KILL) begin
			kill_reg <= i_host_wdata;
		end
	end

	// Protection bytes and poll byte; host first, then qualified RF.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			floor_reg <= `FLOOR_RST;
			opsel_reg <= `OPSEL_RST;
			poll_reg  <= `POLL_RST;
		end else if (i_host_wr) begin
			if (i_host_sel == `SEL_FLOOR) floor_reg <= i_host_wdata;
			if (i_host_sel == `SEL_OPSEL) opsel_reg <= i_host_wdata;
			if (i_host_sel == `SEL_POLL)  poll_reg  <= i_host_wdata;
		end else if (cfg_rf_wr) begin
			if (i_rf_cfg_sel == `SEL_FLOOR) floor_reg <= i_rf_wdata;
			if (i_rf_cfg_sel == `SEL_OPSEL) opsel_reg <= i_rf_wdata;
			if (i_rf_cfg_sel == `SEL_POLL)  poll_reg  <= i_rf_wdata;
		end
	end

	// ------------------------------------------------------------
	// Host read port
	// ------------------------------------------------------------
	always_comb begin
		case (i_host_sel)
			`SEL_KILL:  host_view = kill_reg;
			`SEL_RETRY: host_view = retry_reg;
			`SEL_FLOOR: host_view = floor_reg;
			`SEL_OPSEL: host_view = opsel_reg;
			`SEL_POLL:  host_view = poll_reg;
			default:    host_view = `BYTE_ZERO;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			host_rdata_reg <= `BYTE_ZERO;
		end else if (i_host_rd) begin
			host_rdata_reg <= host_view;
		end
	end

	// ------------------------------------------------------------
	// RF answer
	// ------------------------------------------------------------
	// Every request completes one cycle later; answer low means silence.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			done_reg   <= 1'b0;
			answer_reg <= 1'b0;
			rdata_reg  <= `BYTE_ZERO;
			mask_reg   <= 4'h0;
			sleep_reg  <= 1'b0;
		end else begin
			done_reg   <= i_rf_req;
			sleep_reg  <= login_bad;
			answer_reg <= 1'b0;
			rdata_reg  <= `BYTE_ZERO;
			mask_reg   <= 4'h0;
			if (rf_live) begin
				case (i_rf_op)
					rf_auth_pkg::OP_SENS: begin
						answer_reg <= 1'b1;
						rdata_reg  <= poll_reg;
					end
					rf_auth_pkg::OP_KEY_WR: begin
						answer_reg <= login_ok | key_ovr;
					end
					rf_auth_pkg::OP_CFG_RD: begin
						answer_reg <= cfg_rf_ok;
						rdata_reg  <= cfg_rf_ok ? cfg_rdata : `BYTE_ZERO;
					end
					rf_auth_pkg::OP_CFG_WR: begin
						answer_reg <= cfg_rf_ok;
					end
					rf_auth_pkg::OP_MEM_RD: begin
						answer_reg <= |rd_mask;
						mask_reg   <= rd_mask;
					end
					rf_auth_pkg::OP_MEM_WR: begin
						answer_reg <= wr_ok;
					end
					default: begin
						answer_reg <= 1'b0;
					end
				endcase
			end
		end
	end

	// Lockout flag is published one cycle after the counters move.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			lockout_reg <= 1'b0;
		end else begin
			lockout_reg <= lockout;
		end
	end

	// Outputs straight from flops; tunneling and extended modes are
	// gated outside this block by the published kill bit.
	assign o_host_rdata         = host_rdata_reg;
	assign o_rf_done            = done_reg;
	assign o_rf_answer          = answer_reg;
	assign o_rf_rdata           = rdata_reg;
	assign o_rf_read_mask       = mask_reg;
	assign o_rf_to_sleep        = sleep_reg;
	assign o_authenticated      = state_reg[1];
	assign o_auth_lockout       = lockout_reg;
	assign o_rf_disabled        = kill_reg[`KILL_RF_BIT];
	assign o_ext_modes_disabled = kill_reg[`KILL_EXT_BIT];
	assign o_poll_answer_low    = poll_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	sequence good_login_s;
		login_ok && i_rf_selected;
	endsequence

	sequence bad_login_s;
		login_bad && !host_retry_wr && !lockout;
	endsequence

	chk_login_grants: assert property (
		good_login_s |=> o_authenticated && o_rf_answer ##1 o_authenticated
			|| !i_rf_selected)
		else $error("login did not authenticate");

	chk_fail_silent: assert property (
		login_bad |=> o_rf_to_sleep && !o_rf_answer && !o_authenticated)
		else $error("failed login answered or stayed awake");

	chk_key_read_zero: assert property (
		rf_live && i_rf_op == rf_auth_pkg::OP_CFG_RD
			&& i_rf_cfg_sel <= `SEL_KEY3 |=> o_rf_rdata == `BYTE_ZERO)
		else $error("key byte leaked over RF");

	chk_deselect_drop: assert property (
		!i_rf_selected |=> !o_authenticated)
		else $error("authenticated after deselect");

	chk_locked_write: assert property (
		rf_live && i_rf_op == rf_auth_pkg::OP_MEM_WR && i_rf_blk_locked
			|=> o_rf_done && !o_rf_answer)
		else $error("write to locked block accepted");

	chk_kill_silent: assert property (
		i_rf_req && o_rf_disabled |=> o_rf_done && !o_rf_answer)
		else $error("killed RF part answered");

	chk_success_reload: assert property (
		(good_login_s and !host_retry_wr) |=> retry_reg == `RETRY_FULL
			##1 !lockout)
		else $error("counters not reloaded on success");

	chk_fail_decrement: assert property (
		bad_login_s |=> retry_reg[2:0] == $past(retry_reg[2:0]) - 3'h1
			&& retry_reg[6:4] == retry_reg[2:0])
		else $error("counters not decremented together");

	chk_lockout_refuse: assert property (
		login_try && lockout |=> !o_authenticated && !o_rf_answer
			&& $stable(retry_reg))
		else $error("locked out login changed state");

	chk_host_clears: assert property (
		host_retry_wr |=> retry_reg == ($past(i_host_wdata) & `RETRY_MASK)
			##1 o_auth_lockout == lockout)
		else $error("host counter write not taken");

	chk_sens_byte: assert property (
		rf_live && i_rf_op == rf_auth_pkg::OP_SENS
			|=> o_rf_answer && o_rf_rdata == $past(poll_reg))
		else $error("poll answer byte wrong");

endmodule

//--- src/rf_auth_cfg.svh
// Constants for the RF login and access-protection block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef RF_AUTH_CFG_SVH
`define RF_AUTH_CFG_SVH

// Host and RF configuration byte selector codes.
`define SEL_KEY0      4'h0
`define SEL_KEY1      4'h1
`define SEL_KEY2      4'h2
`define SEL_KEY3      4'h3
`define SEL_KILL      4'h4
`define SEL_RETRY     4'h5
`define SEL_FLOOR     4'h6
`define SEL_OPSEL     4'h7
`define SEL_POLL      4'h8

// Reset values of the stored bytes.
`define KEY_RST       32'h0000_0000
`define KILL_RST      8'h00
`define RETRY_RST     8'h77
`define FLOOR_RST     8'hFF
`define OPSEL_RST     8'h00
`define POLL_RST      8'h44

// Field positions and masks.
`define KILL_RF_BIT   6
`define KILL_EXT_BIT  7
`define OP_WR_BIT     1
`define OP_RD_BIT     0
`define RETRY_MASK    8'h77
`define RETRY_FULL    8'h77
`define CTR_ZERO      3'h0
`define CTR_ONE       3'h1
`define BYTE_ZERO     8'h00

// Last implemented memory block and blocks covered by one read.
`define LAST_BLOCK    8'h7F
`define READ_BLOCKS   4

`endif

//--- src/rf_auth_pkg.sv
// Types shared by the RF login and access-protection block.
// Assumes the constants header sits beside it.
`include "rf_auth_cfg.svh"

package rf_auth_pkg;

	// Kind of RF request presented by the protocol engine.
	typedef enum logic [2:0] {
		OP_SENS   = 3'h0,
		OP_KEY_WR = 3'h1,
		OP_CFG_RD = 3'h2,
		OP_CFG_WR = 3'h3,
		OP_MEM_RD = 3'h4,
		OP_MEM_WR = 3'h5
	} rf_op_t;

	// Login state of the RF side.
	typedef enum logic [1:0] {
		ST_OPEN = 2'b01,
		ST_AUTH = 2'b10
	} auth_state_t;

endpackage

//--- verification/rf_reader_model.sv
// Reader-side stand-in that issues one RF request at a time.
// Assumes the block answers exactly one cycle after taking a request.
`timescale 1ns/1ns

module rf_reader_model (
	// Clock.
	input  wire logic        i_ref_clk,
	// Answer from the block.
	input  wire logic        i_rf_done,
	input  wire logic        i_rf_answer,
	input  wire logic [7:0]  i_rf_rdata,
	input  wire logic [3:0]  i_rf_read_mask,
	// Request to the block.
	output logic             o_rf_req,
	output logic      [2:0]  o_rf_op,
	output logic      [3:0]  o_rf_cfg_sel,
	output logic      [7:0]  o_rf_wdata,
	output logic      [31:0] o_rf_key_data,
	output logic      [7:0]  o_rf_blk_addr,
	output logic             o_rf_blk_locked
);
	// Last answer seen, kept for the bench.
	logic       got_done;
	logic       got_answer;
	logic [7:0] got_rdata;
	logic [3:0] got_mask;

	// Idle lines at time zero.
	initial begin
		o_rf_req = 1'b0;
		o_rf_op = 3'h0;
		o_rf_cfg_sel = 4'h0;
		o_rf_wdata = 8'h00;
		o_rf_key_data = 32'h0000_0000;
		o_rf_blk_addr = 8'h00;
		o_rf_blk_locked = 1'b0;
	end

	// Qualifiers other than the op are inverted on release so a stale value
	// never passes for a held one.
	task automatic send(input logic [2:0] op, input logic [3:0] sel,
		input logic [7:0] wd, input logic [31:0] key,
		input logic [7:0] addr, input logic lk);
		@(posedge i_ref_clk);
		#1;
		o_rf_req = 1'b1;
		o_rf_op = op;
		o_rf_cfg_sel = sel;
		o_rf_wdata = wd;
		o_rf_key_data = key;
		o_rf_blk_addr = addr;
		o_rf_blk_locked = lk;
		@(posedge i_ref_clk);
		#1;
		got_done = i_rf_done;
		got_answer = i_rf_answer;
		got_rdata = i_rf_rdata;
		got_mask = i_rf_read_mask;
		o_rf_req = 1'b0;
		o_rf_cfg_sel = ~sel;
		o_rf_wdata = ~wd;
		o_rf_key_data = ~key;
		o_rf_blk_addr = ~addr;
		o_rf_blk_locked = ~lk;
	endtask
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the RF login and protection block.
// Assumes the reader model drives the RF request side.
`timescale 1ns/1ns
`include "rf_auth_cfg.svh"

module tb_top;
	typedef struct packed {
		logic [3:0] sel;
		logic [7:0] exp;
	} rd_row_t;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        hwr = 1'b0;
	logic        hrd = 1'b0;
	logic [3:0]  hsel = 4'h0;
	logic [7:0]  hwd = 8'h00;
	logic        sel_st = 1'b1;
	logic        pse = 1'b0;
	logic        cfe = 1'b0;
	logic [7:0]  hrdata, rdata, poll, v;
	logic [3:0]  mask, rsel;
	logic [2:0]  rop;
	logic [7:0]  rwd, raddr;
	logic [31:0] rkey;
	logic        rreq, rlk, done, ans, sleep, authd, lck, off, ext;
	int          fails = 0;
	int          check_count = 0;
	int          cyc = 0;
	rd_row_t     rows[10] = '{'{4'h0, 8'h00}, '{4'h1, 8'h00},
		'{4'h2, 8'h00}, '{4'h3, 8'h00}, '{4'h4, 8'h00}, '{4'h5, 8'h77},
		'{4'h6, 8'hFF}, '{4'h7, 8'h00}, '{4'h8, 8'h44}, '{4'h9, 8'h00}};

	// ----------------------------------------
	// Clock, timeout and the two instances
	// ----------------------------------------
	// A hang costs at most a few thousand cycles.
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			end_sim();
		end
	end

	rf_auth_access_control dut_u (.i_ref_clk(clk), .i_sys_rst(rst),
		.i_host_wr(hwr), .i_host_rd(hrd), .i_host_sel(hsel),
		.i_host_wdata(hwd), .o_host_rdata(hrdata), .i_rf_req(rreq),
		.i_rf_op(rop), .i_rf_cfg_sel(rsel), .i_rf_wdata(rwd),
		.i_rf_key_data(rkey), .i_rf_blk_addr(raddr),
		.i_rf_blk_locked(rlk), .i_rf_selected(sel_st),
		.i_prot_set_en(pse), .i_rfcfg_en(cfe), .o_rf_done(done),
		.o_rf_answer(ans), .o_rf_rdata(rdata), .o_rf_read_mask(mask),
		.o_rf_to_sleep(sleep), .o_authenticated(authd),
		.o_auth_lockout(lck), .o_rf_disabled(off),
		.o_ext_modes_disabled(ext), .o_poll_answer_low(poll));

	rf_reader_model rdr_u (.i_ref_clk(clk), .i_rf_done(done),
		.i_rf_answer(ans), .i_rf_rdata(rdata), .i_rf_read_mask(mask),
		.o_rf_req(rreq), .o_rf_op(rop), .o_rf_cfg_sel(rsel),
		.o_rf_wdata(rwd), .o_rf_key_data(rkey), .o_rf_blk_addr(raddr),
		.o_rf_blk_locked(rlk));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic hw(input logic [3:0] s, input logic [7:0] d);
		@(posedge clk);
		#1;
		hwr = 1'b1;
		hsel = s;
		hwd = d;
		@(posedge clk);
		#1;
		hwr = 1'b0;
		hwd = ~d;
	endtask

	task automatic hr(input logic [3:0] s, output logic [7:0] d);
		@(posedge clk);
		#1;
		hrd = 1'b1;
		hsel = s;
		@(posedge clk);
		#1;
		hrd = 1'b0;
		d = hrdata;
	endtask

	// Every RF request must complete on the very next cycle, with the expected answer.
	task automatic rfa(input logic [2:0] op, input logic [3:0] s,
		input logic [7:0] wd, input logic [31:0] key,
		input logic [7:0] a, input logic lk, input logic exp);
		rdr_u.send(op, s, wd, key, a, lk);
		check("rf done", rdr_u.got_done, 1'b1);
		check("rf answer", rdr_u.got_answer, exp);
	endtask

	task automatic login(input logic [31:0] k, input logic e);
		rfa(rf_auth_pkg::OP_KEY_WR, 4'h0, 8'h00, k, 8'h00, 1'b0, e);
	endtask

	task automatic cfg(input logic w, input logic [3:0] s,
		input logic [7:0] d, input logic e);
		rfa(w ? rf_auth_pkg::OP_CFG_WR : rf_auth_pkg::OP_CFG_RD, s, d,
			32'h0000_0000, 8'h00, 1'b0, e);
	endtask

	task automatic mem(input logic w, input logic [7:0] a,
		input logic lk, input logic e);
		rfa(w ? rf_auth_pkg::OP_MEM_WR : rf_auth_pkg::OP_MEM_RD, 4'h0,
			8'h00, 32'h0000_0000, a, lk, e);
	endtask

	task automatic end_sim();
		$display("Checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		tick(4);
		rst = 1'b0;
		check("poll out", poll, 8'h44);
		check("lockout", lck, 1'b0);
		foreach (rows[i]) begin
			hr(rows[i].sel, v);
			check("host byte", v, rows[i].exp);
		end
		$display("reset values done");
		// Poll byte answer and its config gate.
		rfa(rf_auth_pkg::OP_SENS, 4'h0, 8'h00, 32'h0, 8'h00, 1'b0, 1'b1);
		check("sens byte", rdr_u.got_rdata, 8'h44);
		cfg(1'b0, `SEL_POLL, 8'h00, 1'b0);
		// With the RF config enable the poll byte is reachable over RF.
		cfe = 1'b1;
		cfg(1'b1, `SEL_POLL, 8'h5A, 1'b1);
		cfg(1'b0, `SEL_POLL, 8'h00, 1'b1);
		check("poll rf rd", rdr_u.got_rdata, 8'h5A);
		cfe = 1'b0;
		check("poll out", poll, 8'h5A);
		rfa(rf_auth_pkg::OP_SENS, 4'h0, 8'h00, 32'h0, 8'h00, 1'b0, 1'b1);
		check("sens byte", rdr_u.got_rdata, 8'h5A);
		hw(`SEL_POLL, 8'h44);
		check("poll out", poll, 8'h44);
		// A wrong key sleeps and spends one attempt in both copies.
		login(32'h1234_5678, 1'b0);
		check("sleep", sleep, 1'b1);
		hr(`SEL_RETRY, v);
		check("retry", v, 8'h66);
		hw(`SEL_KEY0, 8'h0F);
		hw(`SEL_KEY1, 8'h1E);
		hw(`SEL_KEY2, 8'hC3);
		hw(`SEL_KEY3, 8'hA5);
		login(32'hA5C3_1E0F, 1'b1);
		check("authd", authd, 1'b1);
		hr(`SEL_RETRY, v);
		check("retry", v, 8'h77);
		cfg(1'b0, `SEL_KEY0, 8'h00, 1'b1);
		check("key rd", rdr_u.got_rdata, 8'h00);
		cfg(1'b1, `SEL_KEY0, 8'h55, 1'b0);
		cfg(1'b0, `SEL_KILL, 8'h00, 1'b0);
		cfg(1'b1, `SEL_RETRY, 8'h00, 1'b0);
		pse = 1'b1;
		cfg(1'b1, `SEL_FLOOR, 8'h10, 1'b1);
		pse = 1'b0;
		cfg(1'b0, `SEL_FLOOR, 8'h00, 1'b0);
		mem(1'b1, 8'h05, 1'b1, 1'b0);
		login(32'h0BAD_F00D, 1'b1);
		sel_st = 1'b0;
		tick(2);
		check("authd", authd, 1'b0);
		sel_st = 1'b1;
		login(32'h0BAD_F00D, 1'b1);
		sel_st = 1'b0;
		tick(2);
		sel_st = 1'b1;
		$display("login done");
		// Floor 10h: blocks from 11h upward are guarded.
		hw(`SEL_OPSEL, 8'h03);
		mem(1'b0, 8'h0F, 1'b0, 1'b1);
		check("mask", rdr_u.got_mask, 4'h3);
		mem(1'b0, 8'h20, 1'b0, 1'b0);
		mem(1'b1, 8'h11, 1'b0, 1'b0);
		mem(1'b1, 8'h10, 1'b0, 1'b1);
		hw(`SEL_OPSEL, 8'h01);
		mem(1'b1, 8'h20, 1'b0, 1'b1);
		hw(`SEL_OPSEL, 8'h00);
		mem(1'b0, 8'h20, 1'b0, 1'b1);
		hw(`SEL_OPSEL, 8'h03);
		hw(`SEL_FLOOR, 8'h80);
		mem(1'b0, 8'h20, 1'b0, 1'b1);
		check("mask", rdr_u.got_mask, 4'hF);
		hr(`SEL_FLOOR, v);
		check("floor", v, 8'h80);
		$display("protection done");
		// Last attempt, then the counters must stay at zero.
		hw(`SEL_RETRY, 8'h11);
		login(32'h1111_1111, 1'b0);
		login(32'h1111_1111, 1'b0);
		tick(1);
		check("lockout", lck, 1'b1);
		hr(`SEL_RETRY, v);
		check("retry", v, 8'h00);
		login(32'h0BAD_F00D, 1'b0);
		hw(`SEL_RETRY, 8'h77);
		tick(1);
		check("lockout", lck, 1'b0);
		hw(`SEL_RETRY, 8'h35);
		tick(1);
		check("lockout", lck, 1'b1);
		hw(`SEL_RETRY, 8'h77);
		$display("lockout done");
		hw(`SEL_KILL, 8'h80);
		check("ext off", ext, 1'b1);
		rfa(rf_auth_pkg::OP_SENS, 4'h0, 8'h00, 32'h0, 8'h00, 1'b0, 1'b1);
		hw(`SEL_KILL, 8'hC0);
		check("rf off", off, 1'b1);
		rfa(rf_auth_pkg::OP_SENS, 4'h0, 8'h00, 32'h0, 8'h00, 1'b0, 1'b0);
		hr(`SEL_KILL, v);
		check("kill", v, 8'hC0);
		$display("kill done");
		// A reset in mid-run brings the stored bytes back to defaults.
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		check("rf off", off, 1'b0);
		check("ext off", ext, 1'b0);
		check("lockout", lck, 1'b0);
		check("authd", authd, 1'b0);
		hr(`SEL_KILL, v);
		check("kill", v, 8'h00);
		hr(`SEL_RETRY, v);
		check("retry", v, 8'h77);
		rfa(rf_auth_pkg::OP_SENS, 4'h0, 8'h00, 32'h0, 8'h00, 1'b0, 1'b1);
		check("sens byte", rdr_u.got_rdata, 8'h44);
		$display("reset done");
		end_sim();
	end
endmodule
